// ==== dv/rrs_exec_tb.sv ====
// self-checking bench for the return, rotate and standby executor
`timescale 1ns/1ps
module rrs_exec_tb;
   import rrs_pkg::*;
   logic                 clk_sys;
   logic                 arst_n;
   logic                 wake_req;
   rrs_apb_req_t         req;
   rrs_apb_rsp_t         rsp;
   logic [PC_W-1:0]      pc;
   rrs_ctl_t             ctl;
   int                   num_errors;
   int                   comparisons;
   int                   n_pop;
   int                   n_wclr;
   int                   n_pclr;
   logic [31:0]          rd;
   logic                 err;

   rrs_exec u_rrs_exec
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .apb_req (req),
      .apb_rsp (rsp),
      .wake_req(wake_req),
      .pc      (pc),
      .ctl     (ctl)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // pulses counted, not sampled once, so a double pulse shows
   always @(posedge clk_sys)
   begin
      if (ctl.stack_pop === 1'b1) n_pop++;
      if (ctl.wdt_count_clear === 1'b1) n_wclr++;
      if (ctl.wdt_prescale_clear === 1'b1) n_pclr++;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= wd;
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) check("pready", 32'h1, 32'h0);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // busy ends, or standby is entered
   task automatic wait_done();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end
      while (rd[ST_BUSY_BIT] !== 1'b0 && rd[ST_ASLEEP_BIT] !== 1'b1 && n < 40);
      if (n >= 40) check("done", 32'h1, 32'h0);
   endtask

   task automatic run(input logic [INSTR_W-1:0] op);
      apb(1'b1, OFS_INSTR, {18'h0, op});
      wait_done();
   endtask

   task automatic test_regs();
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status reset", 32'h06, rd);
      apb(1'b0, OFS_ACC, 32'h0);
      check("acc reset", 32'h00, rd);
      apb(1'b1, OFS_STATUS, 32'hFF);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status ro bits", 32'h07, rd);
      apb(1'b1, OFS_PC, 32'h5);
      check("pc write err", 32'h1, {31'h0, err});
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped err", 32'h1, {31'h0, err});
      $display("test regs done");
   endtask

   task automatic test_rot(input logic left, input logic d, input logic [6:0] f,
                           input logic [7:0] v, input logic c);
      logic [7:0]  res;
      logic        cout;
      logic [31:0] pc0;
      res  = left ? {v[6:0], c} : {c, v[7:1]};
      cout = left ? v[7] : v[0];
      apb(1'b1, OFS_FADDR, {25'h0, f});
      apb(1'b1, OFS_FDATA, {24'h0, v});
      apb(1'b1, OFS_STATUS, {31'h0, c});
      apb(1'b1, OFS_ACC, 32'h5A);
      apb(1'b0, OFS_PC, 32'h0);
      pc0 = rd;
      run({2'b00, left ? PFX_RLF[3:0] : PFX_RRF[3:0], d, f});
      apb(1'b0, OFS_ACC, 32'h0);
      check("rot acc", d ? 32'h5A : {24'h0, res}, rd);
      apb(1'b0, OFS_FDATA, 32'h0);
      check("rot file", d ? {24'h0, res} : {24'h0, v}, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("rot status", {26'h0, 5'b00011, cout} & 32'h07, rd & 32'h07);
      apb(1'b0, OFS_PC, 32'h0);
      check("rot pc", pc0 + 32'h1, rd);
      check("rot no pop", 32'h0, n_pop);
      $display("test rotate %0d %0d done", left, d);
   endtask

   task automatic test_returns();
      apb(1'b1, OFS_STATUS, 32'h1);
      apb(1'b1, OFS_STACK, 32'h1ABC);
      run({PFX_LITERAL_RETURN_INSTR, 2'b00, 8'hA7});
      apb(1'b0, OFS_ACC, 32'h0);
      check("literal_return_instr acc", 32'hA7, rd);
      check("literal_return_instr pc", 32'h1ABC, {19'h0, pc});
      check("literal_return_instr pops", 32'h1, n_pop);
      apb(1'b1, OFS_STACK, 32'h0456);
      run(OPC_RETURN);
      check("return pc", 32'h0456, {19'h0, pc});
      check("return pops", 32'h2, n_pop);
      apb(1'b0, OFS_ACC, 32'h0);
      check("return acc", 32'hA7, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("return status", 32'h07, rd);
      $display("test returns done");
   endtask

   task automatic test_standby();
      // neighbour opcode must not be taken for standby
      run(OPC_STANDBY ^ 14'h0001);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("near op status", 32'h06, rd & 32'h1E);
      check("near op wdt", 32'h0, n_wclr);
      run(OPC_STANDBY);
      check("sleep status", 32'h1A, rd & 32'h1E);
      check("wdt clear", 32'h1, n_wclr);
      check("prescale clear", 32'h1, n_pclr);
      check("osc stopped", 32'h1, {31'h0, ctl.osc_stopped});
      apb(1'b1, OFS_ACC, 32'h11);
      check("asleep write err", 32'h1, {31'h0, err});
      repeat (20) @(posedge clk_sys);
      check("still stopped", 32'h1, {31'h0, ctl.osc_stopped});
      wake_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wake_req <= 1'b0;
      wait_done();
      check("woken status", 32'h02, rd & 32'h1E);
      check("osc running", 32'h0, {31'h0, ctl.osc_stopped});
      $display("test standby done");
   endtask

   initial
   begin
      num_errors  = 0;
      comparisons = 0;
      n_pop       = 0;
      n_wclr      = 0;
      n_pclr      = 0;
      arst_n      = 1'b0;
      wake_req    = 1'b0;
      req         = '0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      test_regs();
      test_rot(1'b1, 1'b0, 7'h05, 8'hE6, 1'b0);
      test_rot(1'b0, 1'b0, 7'h05, 8'hE6, 1'b0);
      test_rot(1'b1, 1'b1, 7'h7F, 8'h81, 1'b1);
      test_rot(1'b0, 1'b1, 7'h00, 8'h01, 1'b0);
      test_returns();
      test_standby();
      end_of_test();
   end

   // whole run is a few hundred cycles
   initial
   begin
      #(8 * 20000);
      num_errors++;
      end_of_test();
   end
endmodule

// ==== hdl/rrs_exec.sv ====
// return, rotate and standby executor with apb register access
// Behaviour
// [RQ1] rotate left: carry in, msb out
// [RQ2] destination bit clear: result to accumulator
// [RQ3] destination bit set: result to file
// [RQ4] standby clears the power-down flag
// [RQ5] standby sets the time-expiry flag
// [RQ6] standby clears watchdog counter and prescaler
// [RQ7] standby halts oscillator until wake-up
// [RQ8] standby recognised by its fixed opcode
// [RQ9] literal return: literal, pop, two cycles
// [RQ10] rotate right: carry in msb, lsb out
// [RQ11] return pops at last quarter, then idles; the code first runs a dead second cycle, then goes idle
`timescale 1ns/1ps
module rrs_exec
(
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire rrs_pkg::rrs_apb_req_t apb_req,
   output rrs_pkg::rrs_apb_rsp_t      apb_rsp,
   input  wire logic                  wake_req,
   output logic [rrs_pkg::PC_W-1:0]   pc,
   output rrs_pkg::rrs_ctl_t          ctl
);
   import rrs_pkg::*;

   typedef struct packed
   {
      rrs_state_t         st;
      logic [1:0]         q;
      logic [INSTR_W-1:0] instr;
      logic [DATA_W-1:0]  acc;
      logic               carry;
      logic               to;
      logic               pd;
      logic [PC_W-1:0]    stack_top;
      logic [PC_W-1:0]    pc;
      logic [FADDR_W-1:0] faddr;
      rrs_apb_rsp_t       rsp;
      rrs_ctl_t           ctl;
   } rrs_core_t;

   logic rst_meta;
   logic rst_n;

   // reset released through two stages
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   rrs_core_t s_reg;
   rrs_core_t s_next;

   logic               mem_we;
   logic [FADDR_W-1:0] mem_wa;
   logic [DATA_W-1:0]  mem_wd;
   logic [FADDR_W-1:0] mem_ra;
   logic [DATA_W-1:0]  mem_rdata;
   logic [DATA_W-1:0]  rot_value;
   logic               rot_carry;
   logic               busy;
   logic               access;
   logic               mapped;
   logic               ro_ok;
   rrs_op_t            op;

   assign busy   = (s_reg.st != ST_IDLE);
   assign access = apb_req.psel & apb_req.penable;
   assign op     = rrs_decode(s_reg.instr);
   // operand address held stable from issue, so data is ready by q1
   assign mem_ra = busy ? s_reg.instr[FADDR_W-1:0] : s_reg.faddr;

   rrs_file_mem u_rrs_file_mem
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (mem_we),
      .wr_addr (mem_wa),
      .wr_data (mem_wd),
      .rd_addr (mem_ra),
      .rd_data (mem_rdata)
   );

   rrs_rotate u_rrs_rotate
   (
      .value_in  (mem_rdata),
      .carry_in  (s_reg.carry),
      .to_right  (op == OP_RRF),
      .value_out (rot_value),
      .carry_out (rot_carry)
   );

   always_comb
   begin
      mapped = (apb_req.paddr == OFS_INSTR)  || (apb_req.paddr == OFS_ACC)
            || (apb_req.paddr == OFS_STATUS) || (apb_req.paddr == OFS_STACK)
            || (apb_req.paddr == OFS_PC)     || (apb_req.paddr == OFS_FADDR)
            || (apb_req.paddr == OFS_FDATA);
      // while executing only status and pc may be read
      ro_ok  = !apb_req.pwrite
            && ((apb_req.paddr == OFS_STATUS) || (apb_req.paddr == OFS_PC));
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.rsp.pready             = 1'b0;
      s_next.ctl.stack_pop          = 1'b0;
      s_next.ctl.wdt_count_clear    = 1'b0;
      s_next.ctl.wdt_prescale_clear = 1'b0;
      mem_we = 1'b0;
      mem_wa = s_reg.faddr;
      mem_wd = apb_req.pwdata[DATA_W-1:0];

      // apb: one wait state, effect at the pready edge
      if (access && !s_reg.rsp.pready)
      begin
         s_next.rsp.pready  = 1'b1;
         s_next.rsp.pslverr = !mapped || (busy && !ro_ok)
                           || (apb_req.pwrite && apb_req.paddr == OFS_PC);
         s_next.rsp.prdata  = '0;
         case (apb_req.paddr)
            OFS_INSTR:  s_next.rsp.prdata[INSTR_W-1:0] = s_reg.instr;
            OFS_ACC:    s_next.rsp.prdata[DATA_W-1:0]  = s_reg.acc;
            OFS_STATUS:
            begin
               s_next.rsp.prdata[ST_CARRY_BIT]  = s_reg.carry;
               s_next.rsp.prdata[ST_TO_BIT]     = s_reg.to;
               s_next.rsp.prdata[ST_PD_BIT]     = s_reg.pd;
               s_next.rsp.prdata[ST_ASLEEP_BIT] = (s_reg.st == ST_SLEEP);
               s_next.rsp.prdata[ST_BUSY_BIT]   = busy;
            end
            OFS_STACK:  s_next.rsp.prdata[PC_W-1:0]    = s_reg.stack_top;
            OFS_PC:     s_next.rsp.prdata[PC_W-1:0]    = s_reg.pc;
            OFS_FADDR:  s_next.rsp.prdata[FADDR_W-1:0] = s_reg.faddr;
            OFS_FDATA:  s_next.rsp.prdata[DATA_W-1:0]  = mem_rdata;
            default:    s_next.rsp.prdata = '0;
         endcase
      end

      if (access && s_reg.rsp.pready && !s_reg.rsp.pslverr && apb_req.pwrite)
      begin
         case (apb_req.paddr)
            OFS_INSTR:
            begin
               s_next.instr = apb_req.pwdata[INSTR_W-1:0];
               s_next.st    = ST_RUN;
               s_next.q     = Q_FIRST;
            end
            OFS_ACC:    s_next.acc       = apb_req.pwdata[DATA_W-1:0];
            OFS_STATUS: s_next.carry     = apb_req.pwdata[ST_CARRY_BIT];
            OFS_STACK:  s_next.stack_top = apb_req.pwdata[PC_W-1:0];
            OFS_FADDR:  s_next.faddr     = apb_req.pwdata[FADDR_W-1:0];
            OFS_FDATA:  mem_we           = 1'b1;
            default:    s_next.faddr     = s_reg.faddr;
         endcase
      end

      case (s_reg.st)
         ST_IDLE:
            s_next.q = Q_FIRST;
         ST_RUN:
         begin
            s_next.q = s_reg.q + 2'h1;
            if (s_reg.q == Q_LAST)
            begin
               s_next.st = ST_IDLE;
               s_next.pc = s_reg.pc + 13'h0001;
               case (op)
                  OP_LITERAL_RETURN_INSTR:
                  begin
                     // [RQ9] literal to accumulator, pop
                     s_next.acc           = s_reg.instr[DATA_W-1:0];
                     s_next.pc            = s_reg.stack_top;
                     s_next.ctl.stack_pop = 1'b1;
                     s_next.st            = ST_SECOND;
                  end
                  OP_RETURN:
                  begin
                     // [RQ11] pop on last quarter
                     s_next.pc            = s_reg.stack_top;
                     s_next.ctl.stack_pop = 1'b1;
                     s_next.st            = ST_SECOND;
                  end
                  OP_RLF, OP_RRF:
                  begin
                     // [RQ1] only carry among flags
                     s_next.carry = rot_carry;
                     if (s_reg.instr[DEST_BIT])
                     begin
                        // [RQ3] back into the file
                        mem_we = 1'b1;
                        mem_wa = s_reg.instr[FADDR_W-1:0];
                        mem_wd = rot_value;
                     end
                     else
                        // [RQ2] into the accumulator
                        s_next.acc = rot_value;
                  end
                  OP_STANDBY:
                  begin
                     // [RQ4] power-down flag cleared
                     s_next.pd = 1'b0;
                     // [RQ5] time-expiry flag set
                     s_next.to = 1'b1;
                     // [RQ6] watchdog and prescaler cleared
                     s_next.ctl.wdt_count_clear    = 1'b1;
                     s_next.ctl.wdt_prescale_clear = 1'b1;
                     // [RQ7] oscillator halted
                     s_next.ctl.osc_stopped = 1'b1;
                     s_next.st              = ST_SLEEP;
                  end
                  default:
                     s_next.st = ST_IDLE;
               endcase
            end
         end
         ST_SECOND:
         begin
            // dead cycle of a two-cycle return
            s_next.q = s_reg.q + 2'h1;
            if (s_reg.q == Q_LAST)
               s_next.st = ST_IDLE;
         end
         ST_SLEEP:
         begin
            // [RQ7] held until the wake-up logic asks
            if (wake_req)
            begin
               s_next.ctl.osc_stopped = 1'b0;
               s_next.st              = ST_IDLE;
            end
         end
         default:
            s_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg       <= '0;
         s_reg.st    <= ST_IDLE;
         s_reg.instr <= INSTR_RST;
         s_reg.acc   <= ACC_RST;
         s_reg.pc    <= PC_RST;
         s_reg.to    <= TO_RST;
         s_reg.pd    <= PD_RST;
      end
      else
         s_reg <= s_next;
   end

   assign apb_rsp = s_reg.rsp;
   assign pc      = s_reg.pc;
   assign ctl     = s_reg.ctl;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence last_q(rrs_op_t o);
      s_reg.st == ST_RUN && s_reg.q == Q_LAST && op == o;
   endsequence

   sequence dead_cycle;
      (s_reg.st == ST_SECOND) [*4] ##1 (s_reg.st == ST_IDLE);
   endsequence

   logic rot_any;
   assign rot_any = s_reg.st == ST_RUN && s_reg.q == Q_LAST
                 && (op == OP_RLF || op == OP_RRF);

   rotate_left_a : assert property ( // [RQ1]
      last_q(OP_RLF) |=> s_reg.carry == $past(mem_rdata[7])
         && $stable(s_reg.to) && $stable(s_reg.pd))
      else $error("rotate left carry wrong");

   rotate_acc_a : assert property ( // [RQ2]
      (last_q(OP_RLF) and !s_reg.instr[DEST_BIT])
         |=> s_reg.acc == {$past(mem_rdata[6:0]), $past(s_reg.carry)})
      else $error("rotate left accumulator wrong");

   rotate_back_a : assert property ( // [RQ3]
      (rot_any && s_reg.instr[DEST_BIT])
         |-> mem_we && mem_wa == s_reg.instr[FADDR_W-1:0] ##1 $stable(s_reg.acc))
      else $error("rotate not written back to file");

   standby_pd_a : assert property ( // [RQ4]
      last_q(OP_STANDBY) |=> !s_reg.pd)
      else $error("power-down flag not cleared");
   standby_to_a : assert property ( // [RQ5]
      last_q(OP_STANDBY) |=> s_reg.to)
      else $error("time-expiry flag not set");
   watchdog_clear_a : assert property ( // [RQ6]
      last_q(OP_STANDBY) |=> ctl.wdt_count_clear && ctl.wdt_prescale_clear
         ##1 !ctl.wdt_count_clear)
      else $error("watchdog clear pulse wrong");
   sleep_hold_a : assert property ( // [RQ7]
      (s_reg.st == ST_SLEEP && !wake_req)
         |=> s_reg.st == ST_SLEEP && ctl.osc_stopped)
      else $error("left standby without wake-up");
   standby_code_a : assert property ( // [RQ8]
      (s_reg.st == ST_RUN && s_reg.q == Q_LAST && s_reg.instr == OPC_STANDBY)
         |=> s_reg.st == ST_SLEEP)
      else $error("standby opcode not recognised");
   literal_return_a : assert property ( // [RQ9]
      last_q(OP_LITERAL_RETURN_INSTR) |=> s_reg.acc == $past(s_reg.instr[7:0])
         && pc == $past(s_reg.stack_top) ##0 dead_cycle)
      else $error("literal return wrong");

   rotate_right_a : assert property ( // [RQ10]
      (last_q(OP_RRF) and !s_reg.instr[DEST_BIT])
         |=> s_reg.carry == $past(mem_rdata[0])
         && s_reg.acc == {$past(s_reg.carry), $past(mem_rdata[7:1])})
      else $error("rotate right wrong");

   return_pop_a : assert property ( // [RQ11]
      last_q(OP_RETURN) |=> ctl.stack_pop && $stable(s_reg.carry)
         && pc == $past(s_reg.stack_top) ##0 dead_cycle)
      else $error("return sequence wrong");

   apb_answer_a : assert property (
      (access && !apb_rsp.pready) |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("apb answer timing wrong");

endmodule

// ==== hdl/rrs_file_mem.sv ====
// file register store, one write port, registered read
`timescale 1ns/1ps
module rrs_file_mem
(
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   input  wire logic                        wr_en,
   input  wire logic [rrs_pkg::FADDR_W-1:0] wr_addr,
   input  wire logic [rrs_pkg::DATA_W-1:0]  wr_data,
   input  wire logic [rrs_pkg::FADDR_W-1:0] rd_addr,
   output logic      [rrs_pkg::DATA_W-1:0]  rd_data
);
   import rrs_pkg::*;

   typedef struct packed
   {
      logic [FILE_DEPTH-1:0][DATA_W-1:0] cells;
      logic [DATA_W-1:0]                 rdata;
   } rrs_mem_t;

   rrs_mem_t m_reg;
   rrs_mem_t m_next;

   always_comb
   begin
      m_next = m_reg;
      // same-edge write not seen: read gives the old word
      if (wr_en)
         m_next.cells[wr_addr] = wr_data;
      m_next.rdata = m_reg.cells[rd_addr];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         m_reg <= '0;
      else
         m_reg <= m_next;
   end

   assign rd_data = m_reg.rdata;

endmodule

// ==== hdl/rrs_pkg.sv ====
// shared constants, types and decode for the return/rotate/standby executor
package rrs_pkg;

   localparam int INSTR_W = 14;
   localparam int DATA_W  = 8;
   localparam int PC_W    = 13;
   localparam int FADDR_W = 7;
   localparam int APB_AW  = 8;
   localparam int FILE_DEPTH = 128;

   // apb register byte offsets
   localparam logic [APB_AW-1:0] OFS_INSTR  = 8'h00;
   localparam logic [APB_AW-1:0] OFS_ACC    = 8'h04;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
   localparam logic [APB_AW-1:0] OFS_STACK  = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_PC     = 8'h10;
   localparam logic [APB_AW-1:0] OFS_FADDR  = 8'h14;
   localparam logic [APB_AW-1:0] OFS_FDATA  = 8'h18;

   // status register bit positions
   localparam int ST_CARRY_BIT  = 0;
   localparam int ST_TO_BIT     = 1;
   localparam int ST_PD_BIT     = 2;
   localparam int ST_ASLEEP_BIT = 3;
   localparam int ST_BUSY_BIT   = 4;

   // reset values
   localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
   localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
   localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
   localparam logic               TO_RST    = 1'b1;
   localparam logic               PD_RST    = 1'b1;

   // instruction encodings and fields
   localparam logic [INSTR_W-1:0] OPC_STANDBY = 14'h0063;
   localparam logic [INSTR_W-1:0] OPC_RETURN  = 14'h0008;
   localparam logic [3:0]         PFX_LITERAL_RETURN_INSTR   = 4'hD;
   localparam logic [5:0]         PFX_RLF     = 6'h0D;
   localparam logic [5:0]         PFX_RRF     = 6'h0C;
   localparam int                 DEST_BIT    = 7;

   // quarter phases per instruction cycle
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam logic [1:0] Q_LAST  = 2'h3;

   typedef enum logic [2:0]
   {
      OP_NONE    = 3'b000,
      OP_LITERAL_RETURN_INSTR   = 3'b001,
      OP_RETURN  = 3'b010,
      OP_RLF     = 3'b011,
      OP_RRF     = 3'b100,
      OP_STANDBY = 3'b101
   } rrs_op_t;

   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_RUN    = 2'b01,
      ST_SECOND = 2'b10,
      ST_SLEEP  = 2'b11
   } rrs_state_t;

   typedef struct packed
   {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [APB_AW-1:0] paddr;
      logic [31:0]       pwdata;
   } rrs_apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } rrs_apb_rsp_t;

   typedef struct packed
   {
      logic stack_pop;
      logic wdt_count_clear;
      logic wdt_prescale_clear;
      logic osc_stopped;
   } rrs_ctl_t;

   function automatic rrs_op_t rrs_decode(input logic [INSTR_W-1:0] instr);
      rrs_op_t op;
      op = OP_NONE;
      // [RQ8] standby by full opcode
      if (instr == OPC_STANDBY)
         op = OP_STANDBY;
      else if (instr == OPC_RETURN)
         op = OP_RETURN;
      else if (instr[13:10] == PFX_LITERAL_RETURN_INSTR)
         op = OP_LITERAL_RETURN_INSTR;
      else if (instr[13:8] == PFX_RLF)
         op = OP_RLF;
      else if (instr[13:8] == PFX_RRF)
         op = OP_RRF;
      return op;
   endfunction

endpackage

// ==== hdl/rrs_rotate.sv ====
// one-place rotate through carry, either direction
`timescale 1ns/1ps
module rrs_rotate
(
   input  wire logic [rrs_pkg::DATA_W-1:0] value_in,
   input  wire logic                       carry_in,
   input  wire logic                       to_right,
   output logic      [rrs_pkg::DATA_W-1:0] value_out,
   output logic                            carry_out
);
   import rrs_pkg::*;

   always_comb
   begin
      if (to_right)
      begin
         // [RQ10] right through carry
         value_out = {carry_in, value_in[DATA_W-1:1]};
         carry_out = value_in[0];
      end
      else
      begin
         // [RQ1] left through carry
         value_out = {value_in[DATA_W-2:0], carry_in};
         carry_out = value_in[DATA_W-1];
      end
   end

endmodule
